// [verilog/pptr_regs.sv]
`timescale 1ns/1ps
module pptr_regs
   import pptr_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Management register port.
   input wire pptr_pkg::pptr_reg_req_t reg_req,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // Egress timestamp capture.
   input wire pptr_pkg::pptr_ts_evt_t ts_evt,
   // Correction field adjust.
   input wire pptr_pkg::pptr_corr_req_t corr_req,
   output logic corr_valid,
   output logic [63:0] corr_out,
   // Latency and link delay seen by the datapath.
   output logic [15:0] rx_wire_delay_ns,
   output logic [15:0] tx_wire_delay_ns,
   output logic [31:0] link_delay_ns,
   // Port timing status.
   output logic ptp_status,
   output logic ptp_irq
);
   logic [15:0] rx_lat_r;
   logic [15:0] tx_lat_r;
   logic [15:0] asym_r;
   logic [31:0] dreq_ts_r;
   logic [31:0] sync_time_r;
   logic [31:0] pdrsp_ts_r;
   logic [2:0] flag_r;
   logic [2:0] flag_nxt;
   logic [2:0] en_r;
   logic [31:0] ldly_r;
   logic [31:0] wire_time;
   logic [2:0] set_vec;
   logic [2:0] clr_vec;
   logic [15:0] rd_nxt;

   // Reads have no side effects, so only writes need a decode strobe.
   function automatic logic wr_hit(input pptr_reg_req_t q, input logic [15:0] ofs);
      wr_hit = q.wr && (q.addr == ofs);
   endfunction

   // Packs the three flag-position bits into a 16-bit view.
   function automatic logic [15:0] bits3(input logic [2:0] v);
      bits3 = 16'h0;
      bits3[PPTR_BIT_SYNC] = v[2];
      bits3[PPTR_BIT_DREQ] = v[1];
      bits3[PPTR_BIT_PDRSP] = v[0];
   endfunction

   // Picks the three flag-position bits out of a written word.
   function automatic logic [2:0] pick3(input logic [15:0] w);
      pick3 = {w[PPTR_BIT_SYNC], w[PPTR_BIT_DREQ], w[PPTR_BIT_PDRSP]};
   endfunction

   // True when a capture event of the given kind is presented.
   function automatic logic evt_hit(input pptr_ts_evt_t e, input pptr_msg_t k);
      evt_hit = e.valid && (e.kind == k);
   endfunction

   // Receive latency is only held and exported; this block sees egress stamps only.
   // receive latency.
   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_lat_r <= PPTR_RST_RX_LAT;
      end else if (wr_hit(reg_req, PPTR_OFS_RX_LAT)) begin
         rx_lat_r <= reg_req.wdata;
      end
   end

   // A new transmit latency applies from the next capture; stamps already taken keep the old sum.
   // transmit latency.
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_lat_r <= PPTR_RST_TX_LAT;
      end else if (wr_hit(reg_req, PPTR_OFS_TX_LAT)) begin
         tx_lat_r <= reg_req.wdata;
      end
   end

   // Sign and magnitude are stored as written; the adjuster forms the two's complement value.
   // sign-magnitude asymmetry.
   always_ff @(posedge mclk) begin
      if (rst) begin
         asym_r <= PPTR_RST_ZERO;
      end else if (wr_hit(reg_req, PPTR_OFS_ASYM)) begin
         asym_r <= reg_req.wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ldly_r <= 32'h0;
      end else begin
         if (wr_hit(reg_req, PPTR_OFS_LDLY_LO)) begin
            ldly_r[15:0] <= reg_req.wdata;
         end
         if (wr_hit(reg_req, PPTR_OFS_LDLY_HI)) begin
            ldly_r[31:16] <= reg_req.wdata;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         en_r <= 3'h0;
      end else if (wr_hit(reg_req, PPTR_OFS_TS_EN)) begin
         en_r <= pick3(reg_req.wdata);
      end
   end

   // The sum wraps at 32 bits, the width of the captured time.
   // internal egress point plus transmit latency gives wire time.
   assign wire_time = ts_evt.time_ns + {16'h0, tx_lat_r};

   // One capture strobe per message kind; the remaining kind captures nothing.
   assign set_vec = {evt_hit(ts_evt, PPTR_MSG_SYNC),
                     evt_hit(ts_evt, PPTR_MSG_DREQ),
                     evt_hit(ts_evt, PPTR_MSG_PDRSP)};

   // Each capture writes all 32 bits in one edge, so the high and low words never mix two events.
   // both words together.
   always_ff @(posedge mclk) begin
      if (rst) begin
         sync_time_r <= 32'h0;
      end else if (set_vec[2]) begin
         sync_time_r <= wire_time;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         dreq_ts_r <= 32'h0;
      end else if (set_vec[1]) begin
         dreq_ts_r <= wire_time;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pdrsp_ts_r <= 32'h0;
      end else if (set_vec[0]) begin
         pdrsp_ts_r <= wire_time;
      end
   end

   assign clr_vec = wr_hit(reg_req, PPTR_OFS_TS_STAT) ?
                    pick3(reg_req.wdata) :
                    3'h0;

   // A capture in the same cycle as a clear keeps its flag, so no ready notice is lost.
   // set wins over write-one clear.
   assign flag_nxt = (flag_r & ~clr_vec) | set_vec;

   always_ff @(posedge mclk) begin
      if (rst) begin
         flag_r <= 3'h0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ptp_status <= 1'b0;
      end else begin
         ptp_status <= |flag_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ptp_irq <= 1'b0;
      end else begin
         ptp_irq <= |(flag_nxt & en_r);
      end
   end

   // Unmapped offsets and reserved bits read back as zero.
   always_comb begin
      unique case (reg_req.addr)
         PPTR_OFS_RX_LAT: rd_nxt = rx_lat_r;
         PPTR_OFS_TX_LAT: rd_nxt = tx_lat_r;
         PPTR_OFS_ASYM: rd_nxt = asym_r;
         PPTR_OFS_DREQ_HI: rd_nxt = dreq_ts_r[31:16];
         PPTR_OFS_DREQ_LO: rd_nxt = dreq_ts_r[15:0];
         PPTR_OFS_SYNC_HI: rd_nxt = sync_time_r[31:16];
         PPTR_OFS_SYNC_LO: rd_nxt = sync_time_r[15:0];
         PPTR_OFS_PDRSP_HI: rd_nxt = pdrsp_ts_r[31:16];
         PPTR_OFS_PDRSP_LO: rd_nxt = pdrsp_ts_r[15:0];
         PPTR_OFS_TS_STAT: rd_nxt = bits3(flag_r);
         PPTR_OFS_TS_EN: rd_nxt = bits3(en_r);
         PPTR_OFS_LDLY_LO: rd_nxt = ldly_r[15:0];
         PPTR_OFS_LDLY_HI: rd_nxt = ldly_r[31:16];
         default: rd_nxt = 16'h0;
      endcase
   end

   // Read answer strobe, one cycle after the request.
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_req.rd;
      end
   end

   // Read data holds until the next read, so software may pick it up late.
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= 16'h0;
      end else if (reg_req.rd) begin
         reg_rdata <= rd_nxt;
      end
   end

   // Each export is a flop copy, one cycle behind its register.
   // receive latency export.
   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_wire_delay_ns <= PPTR_RST_RX_LAT;
      end else begin
         rx_wire_delay_ns <= rx_lat_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_wire_delay_ns <= PPTR_RST_TX_LAT;
      end else begin
         tx_wire_delay_ns <= tx_lat_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         link_delay_ns <= 32'h0;
      end else begin
         link_delay_ns <= ldly_r;
      end
   end

   // The adjuster registers its result, so the correction outputs also leave a flop.
   pptr_corr_adj u_corr (
      .mclk(mclk),
      .rst(rst),
      .asym(asym_r),
      .req(corr_req),
      .corr_valid(corr_valid),
      .corr_out(corr_out)
   );
endmodule

// [verilog/pptr_pkg.sv]
package pptr_pkg;

   // Register byte offsets within the port's PTP block.
   localparam logic [15:0] PPTR_OFS_RX_LAT = 16'h0c00;
   localparam logic [15:0] PPTR_OFS_TX_LAT = 16'h0c02;
   localparam logic [15:0] PPTR_OFS_ASYM = 16'h0c04;
   localparam logic [15:0] PPTR_OFS_DREQ_HI = 16'h0c08;
   localparam logic [15:0] PPTR_OFS_DREQ_LO = 16'h0c0a;
   localparam logic [15:0] PPTR_OFS_SYNC_HI = 16'h0c0c;
   localparam logic [15:0] PPTR_OFS_SYNC_LO = 16'h0c0e;
   localparam logic [15:0] PPTR_OFS_PDRSP_HI = 16'h0c10;
   localparam logic [15:0] PPTR_OFS_PDRSP_LO = 16'h0c12;
   localparam logic [15:0] PPTR_OFS_TS_STAT = 16'h0c14;
   localparam logic [15:0] PPTR_OFS_TS_EN = 16'h0c16;
   localparam logic [15:0] PPTR_OFS_LDLY_LO = 16'h0c18;
   localparam logic [15:0] PPTR_OFS_LDLY_HI = 16'h0c1a;

   // Reset values.
   localparam logic [15:0] PPTR_RST_RX_LAT = 16'h019f;
   localparam logic [15:0] PPTR_RST_TX_LAT = 16'h002d;
   localparam logic [15:0] PPTR_RST_ZERO = 16'h0000;

   // Field positions.
   localparam int PPTR_ASYM_SIGN_BIT = 15;
   localparam int PPTR_ASYM_MAG_W = 15;
   localparam int PPTR_BIT_SYNC = 15;
   localparam int PPTR_BIT_DREQ = 14;
   localparam int PPTR_BIT_PDRSP = 13;

   // Message kinds seen by the datapath.
   typedef enum logic [1:0] {
      PPTR_MSG_SYNC = 2'h0,
      PPTR_MSG_DREQ = 2'h1,
      PPTR_MSG_PDRSP = 2'h2,
      PPTR_MSG_OTHER = 2'h3
   } pptr_msg_t;

   // Management register access.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } pptr_reg_req_t;

   // Egress timestamp capture event from the transmit datapath.
   typedef struct packed {
      logic valid;
      pptr_msg_t kind;
      logic [31:0] time_ns;
   } pptr_ts_evt_t;

   // Correction field adjust request from the datapath.
   typedef struct packed {
      logic valid;
      logic egress;
      pptr_msg_t kind;
      logic [63:0] corr;
   } pptr_corr_req_t;

endpackage

// [verilog/pptr_corr_adj.sv]
`timescale 1ns/1ps
// Applies the signed asymmetry value to a correction field, registered.
module pptr_corr_adj
   import pptr_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Configuration.
   input wire logic [15:0] asym,
   // Request and result.
   input wire pptr_pkg::pptr_corr_req_t req,
   output logic corr_valid,
   output logic [63:0] corr_out
);
   logic [63:0] asym_ext;
   logic add_case;
   logic sub_case;

   always_comb begin
      asym_ext = {49'h0, asym[PPTR_ASYM_MAG_W-1:0]};
      if (asym[PPTR_ASYM_SIGN_BIT]) begin
         asym_ext = 64'h0 - asym_ext;
      end
   end

   assign add_case = !req.egress && (req.kind == PPTR_MSG_SYNC || req.kind == PPTR_MSG_PDRSP);
   assign sub_case = req.egress && req.kind == PPTR_MSG_DREQ;

   always_ff @(posedge mclk) begin
      if (rst) begin
         corr_valid <= 1'b0;
         corr_out <= 64'h0;
      end else begin
         corr_valid <= req.valid;
         if (req.valid) begin
            if (add_case) begin
               corr_out <= req.corr + asym_ext;
            end else if (sub_case) begin
               corr_out <= req.corr - asym_ext;
            end else begin
               corr_out <= req.corr;
            end
         end
      end
   end
endmodule

// [bench/pptr_regs_monitor.sv]
`timescale 1ns/1ps
module pptr_regs_monitor
   import pptr_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Watched ports.
   input wire pptr_pkg::pptr_reg_req_t reg_req,
   input wire logic reg_rvalid,
   input wire pptr_pkg::pptr_ts_evt_t ts_evt,
   input wire pptr_pkg::pptr_corr_req_t corr_req,
   input wire logic corr_valid,
   input wire logic [63:0] corr_out,
   input wire logic [15:0] rx_wire_delay_ns,
   input wire logic [15:0] tx_wire_delay_ns,
   input wire logic [31:0] link_delay_ns,
   input wire logic ptp_status,
   input wire logic ptp_irq
);
   logic stat_wr;
   assign stat_wr = reg_req.wr && reg_req.addr == PPTR_OFS_TS_STAT;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   a_reset_copies:
      assert property ($fell(rst) |-> rx_wire_delay_ns == PPTR_RST_RX_LAT && tx_wire_delay_ns == PPTR_RST_TX_LAT
         && link_delay_ns == 32'h0) else $error("latency copies not at reset values");
   a_read_answer:
      assert property (reg_req.rd |=> reg_rvalid) else $error("read not answered");
   a_corr_answer:
      assert property (corr_req.valid |=> corr_valid) else $error("correction not answered");
   a_corr_pass:
      assert property (corr_req.valid && corr_req.kind == PPTR_MSG_OTHER |=> corr_out == $past(corr_req.corr))
         else $error("other message correction altered");
   a_ready_status:
      assert property (ts_evt.valid && ts_evt.kind != PPTR_MSG_OTHER |=> ptp_status) else $error("status not set");
   a_status_holds:
      assert property (ptp_status && !stat_wr && !$past(stat_wr) |=> ptp_status) else $error("flag lost");
   a_irq_gated:
      assert property (ptp_irq |-> ptp_status) else $error("interrupt without flag");
   a_link_copy:
      assert property (reg_req.wr && reg_req.addr == PPTR_OFS_LDLY_LO |=> ##1
         link_delay_ns[15:0] == $past(reg_req.wdata, 2)) else $error("link delay copy wrong");
endmodule
bind pptr_regs pptr_regs_monitor i_mon (.mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rvalid(reg_rvalid),
   .ts_evt(ts_evt), .corr_req(corr_req), .corr_valid(corr_valid), .corr_out(corr_out),
   .rx_wire_delay_ns(rx_wire_delay_ns), .tx_wire_delay_ns(tx_wire_delay_ns),
   .link_delay_ns(link_delay_ns), .ptp_status(ptp_status), .ptp_irq(ptp_irq));

// [bench/pptr_dp_model.sv]
`timescale 1ns/1ps
// Datapath stand-in; idle payloads are inverted so stale values never look valid.
module pptr_dp_model
   import pptr_pkg::*;
(
   // Clock.
   input wire logic mclk,
   // Requests toward the registers.
   output pptr_pkg::pptr_ts_evt_t ts_evt,
   output pptr_pkg::pptr_corr_req_t corr_req
);
   initial begin
      ts_evt = '0;
      corr_req = '0;
   end
   task automatic send_ts(input pptr_msg_t kind, input logic [31:0] t);
      @(posedge mclk);
      ts_evt <= '{1'b1, kind, t};
      @(posedge mclk);
      ts_evt <= '{1'b0, kind, ~t};
   endtask
   task automatic send_corr(input logic eg, input pptr_msg_t kind, input logic [63:0] c);
      @(posedge mclk);
      corr_req <= '{1'b1, eg, kind, c};
      @(posedge mclk);
      corr_req <= '{1'b0, eg, kind, ~c};
   endtask
endmodule

// [bench/pptr_regs_tb.sv]
`timescale 1ns/1ps
module pptr_regs_tb;
   import pptr_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   pptr_reg_req_t reg_req = '0;
   logic [15:0] reg_rdata, rx_d, tx_d, txl, v, ha;
   logic reg_rvalid, corr_valid, ptp_status, ptp_irq;
   logic [63:0] corr_out, c, asv;
   logic [31:0] link_d, t;
   pptr_ts_evt_t ts_evt;
   pptr_corr_req_t corr_req;
   logic [15:0] rd_q[$];
   logic [63:0] corr_q[$];
   int error_cnt = 0;
   int total_checks = 0;
   always #12.5 mclk = ~mclk;
   pptr_regs i_dut (.mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .ts_evt(ts_evt), .corr_req(corr_req), .corr_valid(corr_valid), .corr_out(corr_out), .rx_wire_delay_ns(rx_d),
      .tx_wire_delay_ns(tx_d), .link_delay_ns(link_d), .ptp_status(ptp_status), .ptp_irq(ptp_irq));
   pptr_dp_model i_dp (.mclk(mclk), .ts_evt(ts_evt), .corr_req(corr_req));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_read(input logic [15:0] got, input logic [15:0] exp);
      chk(got, exp, "read");
   endtask
   task automatic chk_corr(input logic [63:0] got, input logic [63:0] exp);
      chk(got, exp, "correction");
   endtask
   task automatic results;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_req <= '{1'b0, 1'b1, a, d};
      @(posedge mclk);
      reg_req <= '0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge mclk);
      reg_req <= '{1'b1, 1'b0, a, 16'h0};
      rd_q.push_back(exp);
      @(posedge mclk);
      reg_req <= '0;
   endtask
   always @(posedge mclk) begin
      if (reg_rvalid === 1'b1) chk_read(reg_rdata, rd_q.pop_front());
      if (corr_valid === 1'b1) chk_corr(corr_out, corr_q.pop_front());
   end
   initial begin
      void'($urandom(32'h9c2c0d10));
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      for (logic [15:0] a = 16'h0c00; a <= 16'h0c1a; a += 16'h2)
         rd(a, (a == 16'h0c00) ? 16'h019f : (a == 16'h0c02) ? 16'h002d : 16'h0);
      v = 16'($urandom);
      wr(PPTR_OFS_RX_LAT, v);
      rd(PPTR_OFS_RX_LAT, v);
      chk(rx_d, v, "rx copy");
      txl = 16'($urandom);
      wr(PPTR_OFS_TX_LAT, txl);
      rd(PPTR_OFS_TX_LAT, txl);
      chk(tx_d, txl, "tx copy");
      wr(PPTR_OFS_LDLY_LO, v);
      wr(PPTR_OFS_LDLY_HI, ~v);
      rd(PPTR_OFS_LDLY_HI, ~v);
      chk(link_d, {~v, v}, "link copy");
      wr(PPTR_OFS_SYNC_HI, 16'hffff);
      rd(PPTR_OFS_SYNC_HI, 16'h0);
      wr(PPTR_OFS_TS_EN, 16'hffff);
      rd(PPTR_OFS_TS_EN, 16'he000);
      for (int k = 0; k < 4; k++) begin
         t = $urandom;
         ha = (k == 0) ? PPTR_OFS_SYNC_HI : (k == 1) ? PPTR_OFS_DREQ_HI : PPTR_OFS_PDRSP_HI;
         i_dp.send_ts(pptr_msg_t'(k), t);
         if (k < 3) rd(ha, 16'((t + txl) >> 16));
         if (k < 3) rd(ha + 16'h2, 16'(t + txl));
      end
      rd(PPTR_OFS_TS_STAT, 16'he000);
      chk(ptp_irq, 1, "irq");
      wr(PPTR_OFS_TS_EN, 16'h0);
      rd(PPTR_OFS_TS_STAT, 16'he000);
      chk(ptp_irq, 0, "masked irq");
      chk(ptp_status, 1, "status");
      wr(PPTR_OFS_TS_STAT, 16'h8000);
      rd(PPTR_OFS_TS_STAT, 16'h6000);
      wr(PPTR_OFS_TS_STAT, 16'h6000);
      rd(PPTR_OFS_TS_STAT, 16'h0);
      chk(ptp_status, 0, "status clear");
      fork
         i_dp.send_ts(PPTR_MSG_SYNC, t);
         wr(PPTR_OFS_TS_STAT, 16'he000);
      join
      rd(PPTR_OFS_TS_STAT, 16'h8000);
      wr(PPTR_OFS_TS_STAT, 16'h8000);
      for (int j = 0; j < 2; j++) begin
         v = {j[0], 15'($urandom)};
         asv = v[15] ? -{49'h0, v[14:0]} : {49'h0, v[14:0]};
         wr(PPTR_OFS_ASYM, v);
         rd(PPTR_OFS_ASYM, v);
         for (int k = 0; k < 8; k++) begin
            c = {$urandom, $urandom};
            corr_q.push_back(k[2] ? ((k[1:0] == 1) ? c - asv : c) : (k[0] == 0 ? c + asv : c));
            i_dp.send_corr(k[2], pptr_msg_t'(k[1:0]), c);
         end
      end
      repeat (2) @(posedge mclk);
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd(PPTR_OFS_RX_LAT, PPTR_RST_RX_LAT);
      rd(PPTR_OFS_ASYM, PPTR_RST_ZERO);
      rd(PPTR_OFS_SYNC_LO, PPTR_RST_ZERO);
      chk(rx_d, PPTR_RST_RX_LAT, "rx after reset");
      chk(link_d, 32'h0, "link after reset");
      for (int i = 0; i < 40 && (rd_q.size() || corr_q.size()); i++) @(posedge mclk);
      if (rd_q.size() || corr_q.size()) chk(1, 0, "answer timeout");
      results();
   end
endmodule
